// ### hdl/fwp_sequencer.sv
// Flash word program sequencer with APB register slave and interrupt.
`timescale 1ns/10ps
module fwp_sequencer import fwp_pkg::*; #(
	parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEFAULT
) (
	// Clock and reset.
	input  wire logic       SYS_CLK,
	input  wire logic       RST,
	// APB slave.
	input  wire logic       PSEL,
	input  wire logic       PENABLE,
	input  wire logic       PWRITE,
	input  wire logic [7:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]     PRDATA,
	output logic            PREADY,
	output logic            PSLVERR,
	// Reset sources that may cut a cycle short.
	input  wire logic       MASTER_CLEAR_RESET,
	input  wire logic       WATCHDOG_TIMER_RESET,
	// Flash array and core.
	output fwp_flash_cmd_t  FLASH_CMD,
	output logic            FLASH_START,
	output logic            FLASH_ABORT,
	output logic            CORE_STALL,
	// Interrupt.
	output logic            IRQ
);

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return hit(a, OFF_PTR_UPPER) || hit(a, OFF_PTR_HIGH) || hit(a, OFF_PTR_LOW) ||
			hit(a, OFF_LATCH) || hit(a, OFF_KEY) || hit(a, OFF_CTRL) ||
			hit(a, OFF_TSTORE) || hit(a, OFF_HOLD) || hit(a, OFF_IRQ_STAT) ||
			hit(a, OFF_IRQ_MASK);
	endfunction

	// Reset pins are asynchronous to SYS_CLK: three stages, change taken when two agree.
	logic [1:0] sync1;
	logic [1:0] sync2;
	logic [1:0] sync3;
	logic [1:0] rst_filt;
	logic [1:0] next_rst_filt;
	logic       abort_ev;

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			next_rst_filt[i] = (sync2[i] == sync3[i]) ? sync3[i] : rst_filt[i];
		end
	end

	assign abort_ev = |(next_rst_filt & ~rst_filt);

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			sync1    <= '0;
			sync2    <= '0;
			sync3    <= '0;
			rst_filt <= '0;
		end else begin
			sync1    <= {WATCHDOG_TIMER_RESET, MASTER_CLEAR_RESET};
			sync2    <= sync1;
			sync3    <= sync2;
			rst_filt <= next_rst_filt;
		end
	end

	// Register state.
	logic [7:0]       ptr_upper;
	logic [7:0]       ptr_high;
	logic [7:0]       ptr_low;
	logic [7:0]       latch;
	logic [7:0]       hold [0:1];
	logic [7:0]       ctrl;
	fwp_unlock_t      ul;
	logic             busy;
	fwp_flash_cmd_t   cmd;
	logic             start_q;
	logic             abort_q;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_mask;
	logic [31:0]      rdata;
	logic             slverr;

	logic [7:0]       next_ptr_upper;
	logic [7:0]       next_ptr_high;
	logic [7:0]       next_ptr_low;
	logic [7:0]       next_latch;
	logic [7:0]       next_hold [0:1];
	logic [7:0]       next_ctrl;
	fwp_unlock_t      next_ul;
	logic             next_busy;
	fwp_flash_cmd_t   next_cmd;
	logic [IRQ_W-1:0] next_irq_stat;
	logic [IRQ_W-1:0] next_irq_mask;
	logic [31:0]      next_rdata;
	logic             next_slverr;

	logic             wr;
	logic             rd_setup;
	logic             rd_acc;
	logic             go_start;
	logic             go_reject;
	logic             tmr_done;
	logic             hw_abort;
	logic [21:0]      ptr;
	logic [21:0]      ptr_inc;
	logic [31:0]      rmux;
	logic [IRQ_W-1:0] irq_ev;
	logic [IRQ_W-1:0] irq_clr;

	assign wr       = PSEL && PENABLE && PWRITE;
	assign rd_setup = PSEL && !PENABLE && !PWRITE;
	assign rd_acc   = PSEL && PENABLE && !PWRITE;
	assign ptr      = {ptr_upper[5:0], ptr_high, ptr_low};
	assign ptr_inc  = ptr + 22'h000001;
	assign hw_abort = busy && abort_ev;

	fwp_timer #(
		.PROG_CYCLES(PROG_CYCLES)
	) fwp_timer_i (
		.clk    (SYS_CLK),
		.rst    (RST),
		.start  (go_start),
		.abort  (hw_abort),
		.running(),
		.done   (tmr_done)
	);

	// Read multiplexer: the key port has no storage and always reads zero.
	always_comb begin
		rmux = '0;
		if (hit(PADDR, OFF_PTR_UPPER)) begin
			rmux[7:0] = ptr_upper & PTRU_MASK;
		end else if (hit(PADDR, OFF_PTR_HIGH)) begin
			rmux[7:0] = ptr_high;
		end else if (hit(PADDR, OFF_PTR_LOW)) begin
			rmux[7:0] = ptr_low;
		end else if (hit(PADDR, OFF_LATCH)) begin
			rmux[7:0] = latch;
		end else if (hit(PADDR, OFF_CTRL)) begin
			rmux[7:0] = ctrl & CTRL_MASK;
		end else if (hit(PADDR, OFF_HOLD)) begin
			rmux[15:0] = {hold[1], hold[0]};
		end else if (hit(PADDR, OFF_IRQ_STAT)) begin
			rmux[IRQ_W-1:0] = irq_stat;
		end else if (hit(PADDR, OFF_IRQ_MASK)) begin
			rmux[IRQ_W-1:0] = irq_mask;
		end
	end

	always_comb begin
		next_ptr_upper = ptr_upper;
		next_ptr_high  = ptr_high;
		next_ptr_low   = ptr_low;
		next_latch     = latch;
		next_hold[0]   = hold[0];
		next_hold[1]   = hold[1];
		next_ctrl      = ctrl;
		next_ul        = ul;
		next_busy      = busy;
		next_cmd       = cmd;
		next_irq_mask  = irq_mask;
		next_rdata     = rdata;
		next_slverr    = slverr;
		go_start       = 1'b0;
		go_reject      = 1'b0;
		if (PSEL && !PENABLE) begin
			next_rdata  = rd_setup ? rmux : '0;
			next_slverr = !mapped(PADDR);
		end
		if (wr) begin
			// Any write other than the expected key breaks the unlock sequence.
			next_ul = UL_IDLE;
			if (hit(PADDR, OFF_PTR_UPPER)) begin
				next_ptr_upper = PWDATA[7:0] & PTRU_MASK;
			end else if (hit(PADDR, OFF_PTR_HIGH)) begin
				next_ptr_high = PWDATA[7:0];
			end else if (hit(PADDR, OFF_PTR_LOW)) begin
				next_ptr_low = PWDATA[7:0];
			end else if (hit(PADDR, OFF_LATCH)) begin
				next_latch = PWDATA[7:0];
			end else if (hit(PADDR, OFF_KEY)) begin
				if (PWDATA[7:0] == UNLOCK_KEY1) begin
					next_ul = UL_FIRST;
				end else if (PWDATA[7:0] == UNLOCK_KEY2 && ul == UL_FIRST) begin
					next_ul = UL_ARMED;
				end
			end else if (hit(PADDR, OFF_TSTORE)) begin
				next_hold[ptr_low[0]] = latch;
				if (PWDATA[TS_POSTINC]) begin
					next_ptr_upper = {2'b00, ptr_inc[21:16]};
					next_ptr_high  = ptr_inc[15:8];
					next_ptr_low   = ptr_inc[7:0];
				end
			end else if (hit(PADDR, OFF_IRQ_MASK)) begin
				next_irq_mask = PWDATA[IRQ_W-1:0];
			end else if (hit(PADDR, OFF_CTRL) && !busy) begin
				next_ctrl = PWDATA[7:0] & CTRL_MASK & ~(8'h01 << CB_GO);
				if (PWDATA[CB_GO]) begin
					// Row writes are not served here, so go also needs word enable.
					if (ul == UL_ARMED && PWDATA[CB_PERMIT] && PWDATA[CB_WORD]) begin
						go_start         = 1'b1;
						next_ctrl[CB_GO] = 1'b1;
						next_busy        = 1'b1;
						next_cmd.addr    = {ptr[ADDR_W-1:1], 1'b0};
						next_cmd.data    = {hold[1], hold[0]};
					end else begin
						go_reject = 1'b1;
					end
				end
			end
		end
		if (tmr_done) begin
			next_ctrl[CB_GO] = 1'b0;
			next_busy        = 1'b0;
		end
		if (hw_abort) begin
			next_ctrl[CB_GO]  = 1'b0;
			next_ctrl[CB_ERR] = 1'b1;
			next_busy         = 1'b0;
		end
	end

	// Status bits clear only where the word read showed them; a new event wins.
	assign irq_ev  = {go_reject, hw_abort, tmr_done};
	assign irq_clr = (rd_acc && hit(PADDR, OFF_IRQ_STAT)) ? rdata[IRQ_W-1:0] : '0;
	assign next_irq_stat = (irq_stat & ~irq_clr) | irq_ev;

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ptr_upper <= RST_BYTE;
			ptr_high  <= RST_BYTE;
			ptr_low   <= RST_BYTE;
			latch     <= RST_BYTE;
			hold[0]   <= RST_BYTE;
			hold[1]   <= RST_BYTE;
			ctrl      <= RST_BYTE;
			ul        <= UL_IDLE;
			busy      <= 1'b0;
			cmd       <= '0;
			start_q   <= 1'b0;
			abort_q   <= 1'b0;
			irq_stat  <= '0;
			irq_mask  <= '0;
			rdata     <= '0;
			slverr    <= 1'b0;
		end else begin
			ptr_upper <= next_ptr_upper;
			ptr_high  <= next_ptr_high;
			ptr_low   <= next_ptr_low;
			latch     <= next_latch;
			hold[0]   <= next_hold[0];
			hold[1]   <= next_hold[1];
			ctrl      <= next_ctrl;
			ul        <= next_ul;
			busy      <= next_busy;
			cmd       <= next_cmd;
			start_q   <= go_start;
			abort_q   <= hw_abort;
			irq_stat  <= next_irq_stat;
			irq_mask  <= next_irq_mask;
			rdata     <= next_rdata;
			slverr    <= next_slverr;
		end
	end

	assign PRDATA      = rdata;
	assign PREADY      = 1'b1;
	assign PSLVERR     = slverr && PSEL && PENABLE;
	assign FLASH_CMD   = cmd;
	assign FLASH_START = start_q;
	assign FLASH_ABORT = abort_q;
	assign CORE_STALL  = busy;
	assign IRQ         = |(irq_stat & irq_mask);

	// Cycle counter read only by the assertions.
	logic [CNT_W-1:0] stall_cnt;
	always_ff @(posedge SYS_CLK) begin
		if (RST || !busy) begin
			stall_cnt <= '0;
		end else begin
			stall_cnt <= stall_cnt + CNT_W'(1);
		end
	end

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	a_go_needs_unlock: assert property (go_start |-> ul == UL_ARMED && PWDATA[CB_PERMIT])
		else $error("program cycle started without unlock and permit");
	a_go_sets_busy: assert property (go_start |=> busy && ctrl[CB_GO] && FLASH_START)
		else $error("go after unlock did not start the cycle");
	a_stall_length: assert property ($fell(busy) && !$past(hw_abort) |->
		$past(stall_cnt) == CNT_W'(PROG_CYCLES - 1))
		else $error("stall length differs from program time");
	a_end_clears_go: assert property (tmr_done |=> !ctrl[CB_GO] && !CORE_STALL)
		else $error("go or stall not released at cycle end");
	a_abort_sets_err: assert property (hw_abort |=> ctrl[CB_ERR] && !busy && FLASH_ABORT)
		else $error("aborted cycle did not raise the error flag");
	a_err_sticky: assert property (ctrl[CB_ERR] && !(wr && hit(PADDR, OFF_CTRL)) |=> ctrl[CB_ERR])
		else $error("error flag cleared without a store");
	a_key_reads_zero: assert property (rd_setup && hit(PADDR, OFF_KEY) |=> PRDATA == '0)
		else $error("key port returned data");
	a_ctrl_unimpl: assert property (rd_setup && hit(PADDR, OFF_CTRL) |=>
		PRDATA[7:6] == 2'b00 && PRDATA[0] == 1'b0)
		else $error("unimplemented control bits read nonzero");
	a_word_data: assert property (FLASH_START |-> FLASH_CMD.addr[0] == 1'b0 &&
		FLASH_CMD.data == {hold[1], hold[0]})
		else $error("program word does not match holding bytes");
	a_ptr_address: assert property (FLASH_START |-> FLASH_CMD.addr[ADDR_W-1:1] ==
		$past(ptr[ADDR_W-1:1]))
		else $error("flash address not taken from the pointer");
	a_store_byte: assert property (wr && hit(PADDR, OFF_TSTORE) |=>
		hold[$past(ptr_low[0])] == $past(latch))
		else $error("table store did not move the latch byte");

	c_program_done: cover property (busy ##1 tmr_done ##1 !busy);
	c_abort: cover property (hw_abort);
	c_reject: cover property (go_reject);
	c_irq: cover property (IRQ && irq_stat[IB_DONE]);

endmodule

// ### hdl/fwp_pkg.sv
// Shared constants and types for the flash word program sequencer.
package fwp_pkg;

	// Clock rate and program time.
	localparam int unsigned CLK_MHZ             = 10;
	localparam int unsigned PROG_US_DEFAULT     = 1000;
	localparam int unsigned PROG_CYCLES_DEFAULT = PROG_US_DEFAULT * CLK_MHZ;

	// Register byte offsets on the bus.
	localparam logic [7:0] OFF_PTR_UPPER = 8'h00;
	localparam logic [7:0] OFF_PTR_HIGH  = 8'h04;
	localparam logic [7:0] OFF_PTR_LOW   = 8'h08;
	localparam logic [7:0] OFF_LATCH     = 8'h0c;
	localparam logic [7:0] OFF_KEY       = 8'h10;
	localparam logic [7:0] OFF_CTRL      = 8'h14;
	localparam logic [7:0] OFF_TSTORE    = 8'h18;
	localparam logic [7:0] OFF_HOLD      = 8'h1c;
	localparam logic [7:0] OFF_IRQ_STAT  = 8'h20;
	localparam logic [7:0] OFF_IRQ_MASK  = 8'h24;

	// Unlock keys.
	localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
	localparam logic [7:0] UNLOCK_KEY2 = 8'haa;

	// Control register bits and implemented-bit masks.
	localparam int unsigned CB_WORD   = 5;
	localparam int unsigned CB_FREE   = 4;
	localparam int unsigned CB_ERR    = 3;
	localparam int unsigned CB_PERMIT = 2;
	localparam int unsigned CB_GO     = 1;
	localparam logic [7:0]  CTRL_MASK = 8'h3e;
	localparam logic [7:0]  PTRU_MASK = 8'h3f;
	localparam logic [7:0]  RST_BYTE  = 8'h00;

	// Table store command: bit 0 requests a post-increment of the pointer.
	localparam int unsigned TS_POSTINC = 0;

	// Interrupt status bits.
	localparam int unsigned IRQ_W     = 3;
	localparam int unsigned IB_DONE   = 0;
	localparam int unsigned IB_ABORT  = 1;
	localparam int unsigned IB_REJECT = 2;

	localparam int unsigned ADDR_W = 21;
	localparam int unsigned CNT_W  = 32;

	typedef enum logic [1:0] {
		UL_IDLE,
		UL_FIRST,
		UL_ARMED
	} fwp_unlock_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [15:0]       data;
	} fwp_flash_cmd_t;

endpackage

// ### hdl/fwp_timer.sv
// Program cycle timer: counts the internal program time once started.
`timescale 1ns/10ps
module fwp_timer import fwp_pkg::*; #(
	parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEFAULT
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst,
	// Control.
	input  wire logic start,
	input  wire logic abort,
	// Status.
	output logic      running,
	output logic      done
);

	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic             next_running;

	assign done = running && (cnt == CNT_W'(1)) && !abort;

	always_comb begin
		next_cnt     = cnt;
		next_running = running;
		if (start) begin
			next_cnt     = CNT_W'(PROG_CYCLES);
			next_running = 1'b1;
		end else if (abort || done) begin
			next_cnt     = '0;
			next_running = 1'b0;
		end else if (running) begin
			next_cnt = cnt - CNT_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt     <= '0;
			running <= 1'b0;
		end else begin
			cnt     <= next_cnt;
			running <= next_running;
		end
	end

endmodule

// ### sim/fwp_core_model.sv
// Core-side model: an APB master that runs the word program sequence.
`timescale 1ns/10ps
module fwp_core_model import fwp_pkg::*; (
	// Clock.
	input  wire logic        clk,
	// APB master.
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	// Raised when a slave never answered.
	output logic             timed_out
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		timed_out = 1'b0;
	end

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) timed_out = 1'b1;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released data flips so that no stale value looks valid.
		pwdata <= ~d;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		xfer(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
		xfer(1'b0, a, 32'h0, q, e);
	endtask

	// Callers hand in only addresses they know to be erased.
	task automatic load_word(input logic [20:0] a, input logic [15:0] d);
		wr(OFF_PTR_UPPER, {27'h0, a[20:16]});
		wr(OFF_PTR_HIGH, {24'h0, a[15:8]});
		wr(OFF_PTR_LOW, {24'h0, a[7:0]});
		wr(OFF_LATCH, {24'h0, d[7:0]});
		wr(OFF_TSTORE, 32'h1);
		wr(OFF_LATCH, {24'h0, d[15:8]});
		wr(OFF_TSTORE, 32'h0);
	endtask

	// The core leaves the interrupt mask as it is from the first key to go.
	task automatic unlock_go(input logic err);
		wr(OFF_CTRL, {28'h2, err, 3'h0});
		wr(OFF_CTRL, {28'h2, err, 3'h4});
		wr(OFF_KEY, {24'h0, UNLOCK_KEY1});
		wr(OFF_KEY, {24'h0, UNLOCK_KEY2});
		wr(OFF_CTRL, {28'h2, err, 3'h6});
	endtask

	task automatic wrap_up;
		wr(OFF_CTRL, 32'h04);
		wr(OFF_CTRL, 32'h00);
	endtask
endmodule

// ### sim/flash_word_program_sequencer_bench.sv
// Self-checking bench for the flash word program sequencer.
`timescale 1ns/10ps
module flash_word_program_sequencer_bench import fwp_pkg::*;;
	localparam int unsigned PC = 16;
	// The pin path takes three or four cycles, so an abort must end the stall this soon.
	localparam int unsigned CUT_MAX = 4;
	logic           clk;
	logic           rst;
	logic           master_clear_reset;
	logic           wdt;
	logic           psel;
	logic           pen;
	logic           pwr;
	logic           rdy;
	logic           slverr;
	logic           start;
	logic           abort;
	logic           stall;
	logic           irq;
	logic           tmo;
	logic [7:0]     paddr;
	logic [31:0]    pwdata;
	logic [31:0]    prdata;
	fwp_flash_cmd_t cmd;
	int             err_total = 0;
	int             n_compared = 0;
	int             n_abort = 0;

	fwp_sequencer #(.PROG_CYCLES(PC)) fwp_sequencer_i (.SYS_CLK(clk), .RST(rst),
		.PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(rdy), .PSLVERR(slverr), .MASTER_CLEAR_RESET(master_clear_reset),
		.WATCHDOG_TIMER_RESET(wdt), .FLASH_CMD(cmd), .FLASH_START(start),
		.FLASH_ABORT(abort), .CORE_STALL(stall), .IRQ(irq));
	fwp_core_model fwp_core_model_i (.clk(clk), .psel(psel), .penable(pen), .pwrite(pwr),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(rdy), .pslverr(slverr),
		.timed_out(tmo));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(negedge clk) begin
		if (abort === 1'b1) n_abort++;
	end

	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", w, e, g);
			err_total++;
		end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string w);
		logic [31:0] q;
		logic        x;
		fwp_core_model_i.rd(a, q, x);
		chk(w, e, q);
	endtask

	task automatic wait_stall(input logic lvl, output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
			if (n > 200) begin
				err_total++;
				report_and_stop();
			end
		end while (stall !== lvl);
	endtask

	task automatic report_and_stop;
		if (tmo === 1'b1) err_total++;
		$display("Compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic t_regs;
		logic [31:0] q;
		logic        e;
		rdc(OFF_CTRL, 32'h0, "ctrl reset");
		fwp_core_model_i.rd(8'hfc, q, e);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
		fwp_core_model_i.wr(OFF_PTR_UPPER, 32'hff);
		rdc(OFF_PTR_UPPER, 32'h3f, "ptr upper");
		fwp_core_model_i.wr(OFF_CTRL, 32'hff);
		rdc(OFF_CTRL, 32'h3c, "ctrl bits");
		rdc(OFF_IRQ_STAT, 32'h4, "go refused");
		fwp_core_model_i.wr(OFF_CTRL, 32'h0);
		$display("test regs done");
	endtask

	task automatic t_program;
		int n;
		fwp_core_model_i.wr(OFF_IRQ_MASK, 32'h7);
		fwp_core_model_i.load_word(21'h1f1234, 16'h5aa5);
		rdc(OFF_HOLD, 32'h5aa5, "holding word");
		fwp_core_model_i.unlock_go(1'b0);
		wait_stall(1'b1, n);
		chk("start", 32'h1, {31'h0, start});
		chk("addr", 32'h1f1234, {11'h0, cmd.addr});
		chk("data", 32'h5aa5, {16'h0, cmd.data});
		wait_stall(1'b0, n);
		chk("stall cycles", PC, n);
		rdc(OFF_CTRL, 32'h24, "go cleared");
		chk("irq set", 32'h1, {31'h0, irq});
		rdc(OFF_IRQ_STAT, 32'h1, "done status");
		@(negedge clk);
		chk("irq clear", 32'h0, {31'h0, irq});
		fwp_core_model_i.wrap_up();
		$display("test program done");
	endtask

	task automatic t_break;
		fwp_core_model_i.wr(OFF_CTRL, 32'h24);
		fwp_core_model_i.wr(OFF_KEY, {24'h0, UNLOCK_KEY1});
		fwp_core_model_i.wr(OFF_KEY, {24'h0, UNLOCK_KEY2});
		rdc(OFF_KEY, 32'h0, "key reads zero");
		fwp_core_model_i.wr(OFF_LATCH, 32'h11);
		fwp_core_model_i.wr(OFF_CTRL, 32'h26);
		@(negedge clk);
		chk("no stall", 32'h0, {31'h0, stall});
		rdc(OFF_IRQ_STAT, 32'h4, "broken unlock");
		fwp_core_model_i.wr(OFF_CTRL, 32'h0);
		$display("test broken unlock done");
	endtask

	task automatic t_abort(input int src);
		int n;
		fwp_core_model_i.load_word(21'h000456, 16'hc3c3);
		fwp_core_model_i.unlock_go(1'b0);
		wait_stall(1'b1, n);
		@(posedge clk);
		if (src == 0) master_clear_reset <= 1'b1;
		else wdt <= 1'b1;
		repeat (3) @(posedge clk);
		master_clear_reset <= 1'b0;
		wdt <= 1'b0;
		wait_stall(1'b0, n);
		// Let the pulse counter settle before it is read.
		@(posedge clk);
		chk("cut short", 32'h1, {31'h0, n <= CUT_MAX});
		chk("abort pulses", src + 1, n_abort);
		rdc(OFF_CTRL, 32'h2c, "error flag");
		rdc(OFF_IRQ_STAT, 32'h2, "abort status");
		rdc(OFF_HOLD, 32'hc3c3, "hold kept");
		fwp_core_model_i.unlock_go(1'b1);
		wait_stall(1'b1, n);
		wait_stall(1'b0, n);
		chk("full cycle", PC, n);
		rdc(OFF_CTRL, 32'h2c, "error kept");
		rdc(OFF_IRQ_STAT, 32'h1, "done again");
		fwp_core_model_i.wrap_up();
		rdc(OFF_CTRL, 32'h0, "error cleared");
		$display("test abort %0d done", src);
	endtask

	initial begin
		rst = 1'b1;
		master_clear_reset = 1'b0;
		wdt = 1'b0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_program();
		t_break();
		t_abort(0);
		t_abort(1);
		report_and_stop();
	end
endmodule
